// File: hw/adc_cycle_defs.svh
// Shared constants of the converter cycle and serial word readout
`ifndef ADC_CYCLE_DEFS_SVH
`define ADC_CYCLE_DEFS_SVH

// ****************************************
// Word layout
// ****************************************
`define WORD_W 32
`define RESULT_W 30
`define EOC_POS 31
`define CHAN_POS 30
`define SIGN_POS 29
`define BIT_CNT_W 6
`define LAST_FALL 6'h1f

// ****************************************
// Result clamp and calibration
// ****************************************
`define FS_POS 30'sh10000000
`define FS_NEG 30'sh2fffffff
`define GAIN_W 16
`define GAIN_SHIFT 14

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 40
`define POR_TIME_NS 1000000
`define POR_CYCLES (`POR_TIME_NS / `CLK_PERIOD_NS)
`define CONV_CYCLES 2048
`define SCK_HALF_CYCLES 4
`define PIN_IDLE 3'h7

`endif

// File: hw/adc_cycle_pkg.sv
// Types shared by the converter cycle modules
package adc_cycle_pkg;

  // Operating cycle states
  typedef enum logic [1:0] {
    ST_POR = 2'h0,
    ST_CONVERT = 2'h1,
    ST_SLEEP = 2'h2,
    ST_OUTPUT = 2'h3
  } cycle_state_type;

endpackage

// File: hw/result_if.sv
// Valid/ready carrier for conversion results between internal modules
`timescale 1ns/1ps

interface result_if #(parameter int W = 30);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// File: hw/conv_engine.sv
// Conversion timer with offset and full-scale correction of the raw result
`timescale 1ns/1ps
`include "adc_cycle_defs.svh"

module conv_engine #(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  // Control
  input wire logic start_in,
  // Modulator result and calibration terms
  input wire logic signed [`RESULT_W-1:0] raw_in,
  input wire logic signed [`RESULT_W-1:0] offset_in,
  input wire logic [`GAIN_W-1:0] gain_in,
  // Result stream
  result_if.source out_if
);

  localparam int CW = $clog2(CONV_CYCLES + 1);

  logic busy_q;
  logic valid_q;
  logic [CW-1:0] count_q;
  logic [`RESULT_W-1:0] data_q;

  // Offset removal, gain trim and clamp to the range codes
  function automatic logic [`RESULT_W-1:0] calibrate(input logic signed [`RESULT_W-1:0] raw,
                                                     input logic signed [`RESULT_W-1:0] offset,
                                                     input logic [`GAIN_W-1:0] gain);
    logic signed [`RESULT_W:0] diff;
    logic signed [`RESULT_W+`GAIN_W+1:0] prod;
    logic [`RESULT_W-1:0] clamped;
    diff = raw - offset;
    prod = (diff * $signed({1'h0, gain})) >>> `GAIN_SHIFT;
    if (prod > `FS_POS) begin
      clamped = `FS_POS;
    end else if (prod < `FS_NEG) begin
      clamped = `FS_NEG;
    end else begin
      clamped = prod[`RESULT_W-1:0];
    end
    // sign bit high for positive, so overrange reads 11 and underrange 00
    calibrate = {~clamped[`RESULT_W-1], clamped[`RESULT_W-2:0]};
  endfunction

  assign out_if.valid = valid_q;
  assign out_if.data = data_q;

  // Conversion timing, result held until taken
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'h0;
      valid_q <= 1'h0;
      count_q <= '0;
      data_q <= '0;
    end else if (clear_in) begin
      busy_q <= 1'h0;
      valid_q <= 1'h0;
      count_q <= '0;
    end else begin
      if (out_if.ready) begin
        valid_q <= 1'h0;
      end
      if (start_in && !busy_q) begin
        busy_q <= 1'h1;
        count_q <= CW'(CONV_CYCLES - 1);
      end else if (busy_q && count_q == '0 && !valid_q) begin
        busy_q <= 1'h0;
        valid_q <= 1'h1;
        data_q <= calibrate(raw_in, offset_in, gain_in);
      end else if (busy_q && count_q != '0) begin
        count_q <= count_q - 1'h1;
      end
    end
  end

endmodule

// File: hw/two_entry_buffer.sv
// Small FIFO in the result path so a stalled reader loses no word
`timescale 1ns/1ps

module two_entry_buffer #(
  parameter int W = 30,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  // Streams
  result_if.sink in_if,
  result_if.source out_if
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;

  // Pointer advance with wrap
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'h1;
  endfunction

  wire logic push = in_if.valid && in_if.ready;
  wire logic pop = out_if.valid && out_if.ready;

  // Honest full and empty
  assign in_if.ready = (count_q != (AW + 1)'(DEPTH));
  assign out_if.valid = (count_q != '0);
  assign out_if.data = mem_q[rd_q];

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_if.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else if (clear_in) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= next_ptr(wr_q);
      end
      if (pop) begin
        rd_q <= next_ptr(rd_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'h1;
      end
    end
  end

endmodule

// File: hw/adc_cycle_serial_readout.sv
// Converter cycle sequencer with serial word readout
`timescale 1ns/1ps
`include "adc_cycle_defs.svh"

module adc_cycle_serial_readout #(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int SCK_HALF = `SCK_HALF_CYCLES,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Supply monitor
  input wire logic supply_low_in,
  // Modulator result and calibration terms
  input wire logic signed [`RESULT_W-1:0] raw_in,
  input wire logic signed [`RESULT_W-1:0] offset_in,
  input wire logic [`GAIN_W-1:0] gain_in,
  // Serial port
  input wire logic cs_n_in,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n_out,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  // Status
  output logic channel_out,
  output logic sleep_out
);

  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam int DW = $clog2(SCK_HALF + 1);

  // ****************************************
  // Registers
  // ****************************************
  logic rst_meta_q;
  logic rst_n_q;
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic cs_prev_q;
  logic sck_prev_q;
  adc_cycle_pkg::cycle_state_type state_q;
  adc_cycle_pkg::cycle_state_type state_d;
  logic [`WORD_W-1:0] shreg_q;
  logic [`WORD_W-1:0] shreg_d;
  logic channel_q;
  logic channel_d;
  logic rise_seen_q;
  logic rise_seen_d;
  logic [`BIT_CNT_W-1:0] fall_cnt_q;
  logic [`BIT_CNT_W-1:0] fall_cnt_d;
  logic [PW-1:0] por_cnt_q;
  logic [PW-1:0] por_cnt_d;
  logic internal_mode_q;
  logic internal_mode_d;
  logic [DW-1:0] div_q;
  logic sck_q;
  logic sck_oe_n_q;
  logic sdo_q;
  logic sdo_oe_n_q;
  logic sleep_q;
  logic start_q;
  logic clear_q;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'h0;
      rst_n_q <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Supply flag, chip select and serial clock pins
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= `PIN_IDLE;
      pin_sync_q <= `PIN_IDLE;
      cs_prev_q <= 1'h1;
      sck_prev_q <= 1'h1;
    end else begin
      pin_meta_q <= {supply_low_in, cs_n_in, sck_in};
      pin_sync_q <= pin_meta_q;
      cs_prev_q <= pin_sync_q[1];
      sck_prev_q <= pin_sync_q[0];
    end
  end

  // Decoded pin levels and edges
  wire logic supply_low = pin_sync_q[2];
  wire logic cs_n = pin_sync_q[1];
  wire logic sck_level = pin_sync_q[0];
  wire logic cs_fall = cs_prev_q & ~cs_n;
  wire logic ext_rise = ~sck_prev_q & sck_level;
  wire logic ext_fall = sck_prev_q & ~sck_level;
  wire logic int_run = internal_mode_q && (state_q == adc_cycle_pkg::ST_OUTPUT) && !cs_n;
  wire logic int_tick = (div_q == DW'(SCK_HALF - 1));
  wire logic sck_rise = internal_mode_q ? (int_run & int_tick & ~sck_q) : ext_rise;
  wire logic sck_fall = internal_mode_q ? (int_run & int_tick & sck_q) : ext_fall;
  wire logic last_fall = (fall_cnt_q == `LAST_FALL);

  // ****************************************
  // Result path
  // ****************************************
  result_if #(.W(`RESULT_W)) push_if ();
  result_if #(.W(`RESULT_W)) pop_if ();

  // Words are taken only while the cycle sits in conversion
  assign pop_if.ready = (state_q == adc_cycle_pkg::ST_CONVERT) && !supply_low;

  conv_engine #(.CONV_CYCLES(CONV_CYCLES)) engine (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .clear_in(clear_q),
    .start_in(start_q),
    .raw_in(raw_in),
    .offset_in(offset_in),
    .gain_in(gain_in),
    .out_if(push_if)
  );

  two_entry_buffer #(.W(`RESULT_W), .DEPTH(BUF_DEPTH)) result_buffer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .clear_in(clear_q),
    .in_if(push_if),
    .out_if(pop_if)
  );

  // ****************************************
  // Cycle sequencer
  // ****************************************

  // Next state, shift register, channel and mode latch
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    channel_d = channel_q;
    rise_seen_d = rise_seen_q;
    fall_cnt_d = fall_cnt_q;
    por_cnt_d = por_cnt_q;
    internal_mode_d = cs_fall ? sck_level : internal_mode_q;
    if (supply_low) begin
      state_d = adc_cycle_pkg::ST_POR;
      por_cnt_d = PW'(POR_CYCLES);
      shreg_d = '0;
      channel_d = 1'h0;
      rise_seen_d = 1'h0;
      fall_cnt_d = '0;
      internal_mode_d = internal_mode_q;
    end else begin
      unique case (state_q)
        adc_cycle_pkg::ST_POR: begin
          shreg_d = '0;
          channel_d = 1'h0;
          if (por_cnt_q == '0) begin
            state_d = adc_cycle_pkg::ST_CONVERT;
            internal_mode_d = sck_level;
          end else begin
            por_cnt_d = por_cnt_q - 1'h1;
          end
        end
        adc_cycle_pkg::ST_CONVERT: begin
          if (pop_if.valid) begin
            shreg_d = {1'h0, channel_q, pop_if.data};
            channel_d = ~channel_q;
            state_d = adc_cycle_pkg::ST_SLEEP;
          end
        end
        adc_cycle_pkg::ST_SLEEP: begin
          if (!cs_n) begin
            state_d = adc_cycle_pkg::ST_OUTPUT;
            rise_seen_d = 1'h0;
            fall_cnt_d = '0;
          end
        end
        adc_cycle_pkg::ST_OUTPUT: begin
          if (cs_n) begin
            state_d = rise_seen_q ? adc_cycle_pkg::ST_CONVERT : adc_cycle_pkg::ST_SLEEP;
          end else begin
            if (sck_rise) begin
              rise_seen_d = 1'h1;
            end
            if (sck_fall && rise_seen_q) begin
              fall_cnt_d = fall_cnt_q + 1'h1;
              if (last_fall) begin
                state_d = adc_cycle_pkg::ST_CONVERT;
              end else begin
                shreg_d = {shreg_q[`WORD_W-2:0], 1'h0};
              end
            end
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= adc_cycle_pkg::ST_POR;
      shreg_q <= '0;
      channel_q <= 1'h0;
      rise_seen_q <= 1'h0;
      fall_cnt_q <= '0;
      por_cnt_q <= PW'(POR_CYCLES);
      internal_mode_q <= 1'h1;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      channel_q <= channel_d;
      rise_seen_q <= rise_seen_d;
      fall_cnt_q <= fall_cnt_d;
      por_cnt_q <= por_cnt_d;
      internal_mode_q <= internal_mode_d;
    end
  end

  // ****************************************
  // Pins and status
  // ****************************************

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= '0;
      sck_q <= 1'h0;
      sck_oe_n_q <= 1'h1;
    end else if (int_run) begin
      div_q <= int_tick ? '0 : div_q + 1'h1;
      sck_q <= int_tick ? ~sck_q : sck_q;
      sck_oe_n_q <= 1'h0;
    end else begin
      div_q <= '0;
      sck_q <= 1'h0;
      sck_oe_n_q <= 1'h1;
    end
  end

  // status bit while converting, data bit otherwise
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sdo_q <= 1'h0;
      sdo_oe_n_q <= 1'h1;
      sleep_q <= 1'h0;
      start_q <= 1'h0;
      clear_q <= 1'h1;
    end else begin
      sdo_q <= (state_d == adc_cycle_pkg::ST_CONVERT) ? 1'h1 : shreg_d[`EOC_POS];
      sdo_oe_n_q <= cs_n || (state_d == adc_cycle_pkg::ST_POR);
      sleep_q <= (state_d == adc_cycle_pkg::ST_SLEEP);
      start_q <= (state_d == adc_cycle_pkg::ST_CONVERT) && (state_q != adc_cycle_pkg::ST_CONVERT);
      clear_q <= (state_d == adc_cycle_pkg::ST_POR);
    end
  end

  assign sck_out = sck_q;
  assign sck_oe_n_out = sck_oe_n_q;
  assign sdo_out = sdo_q;
  assign sdo_oe_n_out = sdo_oe_n_q;
  assign channel_out = channel_q;
  assign sleep_out = sleep_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_por_exit;
    state_q == adc_cycle_pkg::ST_POR ##1 state_q == adc_cycle_pkg::ST_CONVERT;
  endsequence
  sequence s_load;
    state_q == adc_cycle_pkg::ST_CONVERT ##1 state_q == adc_cycle_pkg::ST_SLEEP;
  endsequence

  property p_por_channel;
    s_por_exit |-> channel_q == 1'h0;
  endproperty
  a_por_channel: assert property (p_por_channel) else $error("channel not 0 after reset pulse");
  property p_alternate;
    s_load |-> channel_q != $past(channel_q) && shreg_q[`CHAN_POS] == $past(channel_q);
  endproperty
  a_alternate: assert property (p_alternate) else $error("channel did not alternate");
  property p_word_status;
    s_load |-> shreg_q[`EOC_POS] == 1'h0 && sdo_q == 1'h0;
  endproperty
  a_word_status: assert property (p_word_status) else $error("loaded word shows conversion busy");
  property p_order;
    (state_q == adc_cycle_pkg::ST_SLEEP && $past(state_q) != adc_cycle_pkg::ST_SLEEP)
      |-> $past(state_q) == adc_cycle_pkg::ST_CONVERT || $past(state_q) == adc_cycle_pkg::ST_OUTPUT;
  endproperty
  a_order: assert property (p_order) else $error("sleep entered out of order");
  property p_sleep_hold;
    state_q == adc_cycle_pkg::ST_SLEEP && cs_n && !supply_low |=> state_q == adc_cycle_pkg::ST_SLEEP;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left sleep with select high");
  property p_keep;
    state_q == adc_cycle_pkg::ST_SLEEP ##1 state_q == adc_cycle_pkg::ST_SLEEP |-> $stable(shreg_q);
  endproperty
  a_keep: assert property (p_keep) else $error("result changed during sleep");
  property p_wake;
    state_q == adc_cycle_pkg::ST_SLEEP && !cs_n && !supply_low |=> state_q == adc_cycle_pkg::ST_OUTPUT;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on select low");
  property p_abort;
    state_q == adc_cycle_pkg::ST_OUTPUT && cs_n && !supply_low
      |=> state_q == ($past(rise_seen_q) ? adc_cycle_pkg::ST_CONVERT : adc_cycle_pkg::ST_SLEEP);
  endproperty
  a_abort: assert property (p_abort) else $error("wrong state after select release");
  property p_last_bit;
    state_q == adc_cycle_pkg::ST_OUTPUT && !cs_n && !supply_low && sck_fall && rise_seen_q && last_fall
      |=> state_q == adc_cycle_pkg::ST_CONVERT && start_q;
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("no new conversion after word");
  property p_fall_only;
    state_q == adc_cycle_pkg::ST_OUTPUT && $past(state_q) == adc_cycle_pkg::ST_OUTPUT && $changed(sdo_q)
      |-> $past(sck_fall);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("data changed off a falling edge");
  property p_supply;
    supply_low |=> state_q == adc_cycle_pkg::ST_POR && sdo_oe_n_q;
  endproperty
  a_supply: assert property (p_supply) else $error("not held in reset on supply low");

endmodule

// File: dv/host_reader.sv
// Host model that selects the converter and reads its serial word
`timescale 1ns/1ps

module host_reader (
  // Clock
  input wire logic clk_in,
  // Serial port
  input wire logic sdo_in,
  input wire logic sck_wire_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic sck_en_out
);
  // ****************************************
  // Frame tasks
  // ****************************************
  // Idle: deselected, clock held low and driven
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sck_en_out = 1'b1;
  end

  // Pull select low and give the device time to wake
  task automatic select();
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask

  // Release select, clock back to driven low
  task automatic deselect();
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sck_en_out = 1'b1;
    @(negedge clk_in);
  endtask

  // sample at rise
  // High 3 clk, low 5 clk: 320 ns period, bit settled before each rise
  task automatic read_ext(input int n, output logic [31:0] word);
    word = '0;
    for (int i = 0; i < n; i++) begin
      sck_out = 1'b1;
      word = {word[30:0], sdo_in};
      repeat (3) @(negedge clk_in);
      sck_out = 1'b0;
      repeat (5) @(negedge clk_in);
    end
  endtask

  // released clock mode
  // Released line floats high on the pull-up, so the device drives the clock
  task automatic read_int(output logic [31:0] word);
    word = '0;
    sck_en_out = 1'b0;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    for (int i = 0; i < 32; i++) begin
      @(posedge sck_wire_in);
      word = {word[30:0], sdo_in};
    end
    repeat (8) @(negedge clk_in);
  endtask
endmodule

// File: dv/adc_cycle_serial_readout_bench.sv
// Self-checking bench for the converter cycle and serial readout
`timescale 1ns/1ps

module adc_cycle_serial_readout_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_low = 1'b0;
  logic signed [29:0] raw = 30'sh0;
  logic signed [29:0] offset = 30'sh10;
  logic [15:0] gain = 16'h4000;
  logic cs_n, sck_host, sck_en, sck_wire, sck_dev, sck_oe_n, sdo, sdo_oe_n, channel, sleep;
  logic [31:0] word;
  logic sdo_line;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  // Clock line: device, then host, else pull-up
  assign sck_wire = !sck_oe_n ? sck_dev : (sck_en ? sck_host : 1'b1);
  // Data line: undriven it shows the inverse, so a read off select fails
  assign sdo_line = !sdo_oe_n ? sdo : ~sdo;

  adc_cycle_serial_readout #(.POR_CYCLES(20), .CONV_CYCLES(16), .SCK_HALF(4), .BUF_DEPTH(2)) DUT (
    .clk_in(clk), .arst_n_in(arst_n), .supply_low_in(supply_low), .raw_in(raw),
    .offset_in(offset), .gain_in(gain), .cs_n_in(cs_n), .sck_in(sck_wire), .sck_out(sck_dev),
    .sck_oe_n_out(sck_oe_n), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n), .channel_out(channel),
    .sleep_out(sleep));

  host_reader host (.clk_in(clk), .sdo_in(sdo_line), .sck_wire_in(sck_wire), .cs_n_out(cs_n),
    .sck_out(sck_host), .sck_en_out(sck_en));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  always #20 clk = ~clk;

  // Cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count = bad_count + 1;
      $display("unexpected cycle_count expected below 6000 seen 6000");
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Word: flag low, channel, inverted sign, clamped value
  function automatic logic [31:0] exp_word(input logic ch, input logic signed [29:0] r);
    logic signed [30:0] v;
    v = r - offset;
    if (v > 31'sh10000000) v = 31'sh10000000;
    if (v < 31'sh6fffffff) v = 31'sh6fffffff;
    return {1'b0, ch, ~v[29], v[28:0]};
  endfunction

  task automatic wait_sleep(input int limit);
    for (int i = 0; i < limit && sleep !== 1'b1; i++) @(negedge clk);
    check("sleep_out", 1, sleep);
  endtask

  task automatic read32();
    host.select();
    host.read_ext(32, word);
    host.deselect();
  endtask

  task automatic conv_read(input logic signed [29:0] r, input logic ch, input string name);
    raw = r;
    wait_sleep(200);
    read32();
    check(name, exp_word(ch, r), word);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ranges();
    conv_read(30'sh0123456, 1'b0, "first word");
    conv_read(30'sh15000000, 1'b1, "overrange word");
    conv_read(30'sh2a000000, 1'b0, "underrange word");
  endtask

  task automatic t_peek();
    raw = 30'sh3ffff000;
    wait_sleep(200);
    raw = 30'sh0;
    host.select();
    check("sdo_out", 0, sdo);
    check("sdo_oe_n_out", 0, sdo_oe_n);
    check("sleep_out", 0, sleep);
    host.deselect();
    wait_sleep(10);
    read32();
    check("kept word", exp_word(1'b1, 30'sh3ffff000), word);
  endtask

  task automatic t_abort();
    wait_sleep(200);
    raw = 30'sh00abcdef;
    host.select();
    host.read_ext(9, word);
    host.deselect();
    check("partial word", exp_word(1'b0, 30'sh0) >> 23, word);
    repeat (3) @(negedge clk);
    host.select();
    check("sdo_out", 1, sdo);
    check("sleep_out", 0, sleep);
    for (int i = 0; i < 60 && sdo !== 1'b0; i++) @(negedge clk);
    check("sdo_out", 0, sdo);
    repeat (4) @(negedge clk);
    host.read_ext(32, word);
    host.deselect();
    check("word after abort", exp_word(1'b1, 30'sh00abcdef), word);
  endtask

  task automatic t_internal();
    raw = 30'sh0fffffff;
    wait_sleep(200);
    host.read_int(word);
    host.deselect();
    check("internal clock word", exp_word(1'b0, 30'sh0fffffff), word);
  endtask

  task automatic t_supply();
    int n;
    supply_low = 1'b1;
    raw = 30'sh10;
    repeat (6) @(negedge clk);
    check("channel_out", 0, channel);
    check("sleep_out", 0, sleep);
    supply_low = 1'b0;
    for (n = 0; n < 200 && sleep !== 1'b1; n++) @(negedge clk);
    check("reset_then_conversion_long_enough", 1, n >= 36);
    conv_read(30'sh10, 1'b0, "word after supply reset");
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    t_ranges();
    t_peek();
    t_abort();
    t_internal();
    t_supply();
    print_verdict();
  end
endmodule
